// *** rtl/fzpg_pkg.sv ***
// fzpg_pkg: constants for the fault-zone and power-good configuration block
// assumes a 100 MHz core clock and a host-side command decoder on the same clock
package fzpg_pkg;
   localparam int NUM_CH    = 8;
   localparam int NUM_PIN   = 4;               // zone0 a, zone0 b, zone1 a, zone1 b
   // command codes seen on the command port (values arbitrary)
   localparam logic [7:0] CMD_CFG_ALL = 8'hD1;
   localparam logic [7:0] CMD_PROP_A  = 8'hD2;
   localparam logic [7:0] CMD_PROP_B  = 8'hD3;
   localparam logic [7:0] CMD_RESP_A  = 8'hD4;
   localparam logic [7:0] CMD_RESP_B  = 8'hD5;
   localparam logic [7:0] CMD_PG_EN   = 8'hD6;
   localparam logic [7:0] CMD_STATUS  = 8'hD7;
   // field positions
   localparam int CFG_PEC_BIT  = 2;
   localparam int CFG_LONG_BIT = 1;
   localparam int CFG_WPU_BIT  = 0;
   localparam int PG_WDOG_BIT  = 8;
   // reset values
   localparam logic [2:0] CFG_RST    = 3'h0;
   localparam logic [7:0] PROP_RST   = 8'h00;
   localparam logic [7:0] RESP_RST   = 8'h00;
   localparam logic [8:0] PG_EN_RST  = 9'h000;
   // odd channels may be in high-resolution mode
   localparam logic [7:0] ODD_CH_MASK = 8'hAA;
   // timing
   localparam int CLK_MHZ      = 100;
   localparam int PIN_QUAL_NS  = 10000;        // 10 us pin qualification
   localparam int PIN_QUAL_CYC = (PIN_QUAL_NS * CLK_MHZ + 999) / 1000;
   localparam int BUS_TO_US    = 25;           // normal bus timeout
   localparam int BUS_TO_CYC   = BUS_TO_US * CLK_MHZ;
   localparam int TO_MULT      = 8;
endpackage

// *** rtl/fzpg_sync.sv ***
// fzpg_sync: two-flop level synchroniser, one bit per lane
// assumes each lane is a slow level; multi-bit lanes are treated independently
`timescale 1ns/1ps
module fzpg_sync #(
   parameter int W = 4
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// *** rtl/fzpg_qual.sv ***
// fzpg_qual: qualifies a low fault pin once it has stayed low for CYC cycles
// assumes pin_low is already synchronous to clk
`timescale 1ns/1ps
module fzpg_qual #(
   parameter int CYC = 1000
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic pin_low,
   output logic      qual_q
);
   localparam int CW = $clog2(CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(CYC - 1);
   logic [CW-1:0] cnt_q;

   // count low time, drop at once on release
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q  <= '0;
         qual_q <= 1'b0;
      end else if (ce) begin
         if (!pin_low) begin
            cnt_q  <= '0;
            qual_q <= 1'b0;
         end else if (cnt_q == LAST) begin
            qual_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + CW'(1);
         end
      end
   end
endmodule

// *** rtl/fzpg_top.sv ***
// fzpg_top: configuration word, fault-zone propagation and power-good mapping
// assumes a command decoder on core_clk and fault pins resolved on the link clock
//
// Behaviour
// - pec bit 0 accepts packets with or without pec; 1 requires pec
// - long-timeout bit multiplies the bus timeout interval by eight
// - pull-up disable bit: 0 weak pull-up, 1 three-state, unless forced off
// - channels 0-3 reach only zone-0 pins, 4-7 only zone-1; page picks zone
// - first propagate bit lets a faulted-off channel pull its zone's first pin low
// - second propagate bit lets a faulted-off channel pull its zone's second pin low
// - propagate bits 15:1 ignore writes and read zero
// - a low pin has no effect on channels whose response bit is zero
// - enabled channels' power-good is ANDed into the power-good pin
// - watchdog enable bit ANDs watchdog-not-expired into power-good
// - odd channels in high-resolution mode never contribute to power-good
// - power-good enable bits 15:9 read zero
// - response bit 1: shut channel after pin low 10 us, restart on release
// - pin shutdown pulls alert low and sets the channel status bit
`timescale 1ns/1ps
module fzpg_top
   import fzpg_pkg::*;
#(
   parameter int TO_CYC = BUS_TO_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        link_clk,
   input  wire logic        cmd_valid,
   input  wire logic        cmd_write,
   input  wire logic [7:0]  cmd_code,
   input  wire logic [2:0]  cmd_page,
   input  wire logic [15:0] cmd_wdata,
   output logic      [15:0] rd_data_q,
   output logic             rd_valid_q,
   output logic             cmd_err_q,
   input  wire logic        pkt_done,
   input  wire logic        pkt_has_pec,
   output logic             pec_reject_q,
   input  wire logic        bus_busy,
   output logic             bus_timeout_q,
   input  wire logic        vin_en_force_off,
   output logic             vin_en_pullup_q,
   output logic             vin_en_low_q,
   input  wire logic [7:0]  chan_faulted_off,
   input  wire logic [7:0]  chan_pg,
   input  wire logic [7:0]  adc_hires,
   input  wire logic        wdog_ok,
   output logic      [7:0]  chan_pin_off_q,
   output logic             alert_output_o_q,
   output logic             alert_output_oe_q,
   output logic             pwrgd_q,
   input  wire logic        zone0_fault_pin_a_i,
   output logic             zone0_fault_pin_a_o_q,
   output logic             zone0_fault_pin_a_oe_q,
   input  wire logic        zone0_fault_pin_b_i,
   output logic             zone0_fault_pin_b_o_q,
   output logic             zone0_fault_pin_b_oe_q,
   input  wire logic        zone1_fault_pin_a_i,
   output logic             zone1_fault_pin_a_o_q,
   output logic             zone1_fault_pin_a_oe_q,
   input  wire logic        zone1_fault_pin_b_i,
   output logic             zone1_fault_pin_b_o_q,
   output logic             zone1_fault_pin_b_oe_q
);
   localparam logic [31:0] TO_BASE = 32'(TO_CYC);
   localparam logic [31:0] TO_LONG = 32'(TO_CYC * TO_MULT);

   logic [2:0]  cfg_q;
   logic [7:0]  prop_a_q;
   logic [7:0]  prop_b_q;
   logic [7:0]  resp_a_q;
   logic [7:0]  resp_b_q;
   logic [8:0]  pg_en_q;
   logic [7:0]  status_q;
   logic [7:0]  status_d;
   logic [7:0]  pin_off_d;
   logic [7:0]  pg_eff;
   logic        pg_d;
   logic [3:0]  drive_req_q;
   logic [3:0]  drive_req_d;
   logic [3:0]  pin_low_core;
   logic [3:0]  pin_qual;
   logic [15:0] rd_d;
   logic        err_d;
   logic [7:0]  rd_code_q;
   logic [31:0] to_cnt_q;
   logic [31:0] to_limit;
   logic [1:0]  lrst_q;
   logic        lrst_n;
   logic [3:0]  pin_raw_low;
   logic [3:0]  pin_low_link;
   logic [3:0]  pin_low_q;
   logic [3:0]  drive_link;
   logic [3:0]  fault_oe_q;

   // true when the current command targets the given code
   function automatic logic cmd_hit(input logic [7:0] code);
      return cmd_valid && (cmd_code == code);
   endfunction

   // configuration word, only the low three bits are held
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cfg_q <= CFG_RST;
      end else if (ce && cmd_write && cmd_hit(CMD_CFG_ALL)) begin
         cfg_q <= cmd_wdata[2:0];
      end
   end

   // per-page propagate bits; bits above bit 0 are dropped
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         prop_a_q <= PROP_RST;
         prop_b_q <= PROP_RST;
      end else if (ce && cmd_write) begin
         if (cmd_hit(CMD_PROP_A)) prop_a_q[cmd_page] <= cmd_wdata[0];
         if (cmd_hit(CMD_PROP_B)) prop_b_q[cmd_page] <= cmd_wdata[0];
      end
   end

   // per-zone response bits; page bit 2 selects the zone
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         resp_a_q <= RESP_RST;
         resp_b_q <= RESP_RST;
      end else if (ce && cmd_write) begin
         if (cmd_hit(CMD_RESP_A)) resp_a_q[{cmd_page[2], 2'b00} +: 4] <= cmd_wdata[3:0];
         if (cmd_hit(CMD_RESP_B)) resp_b_q[{cmd_page[2], 2'b00} +: 4] <= cmd_wdata[3:0];
      end
   end

   // power-good source enables, bits 15:9 not stored
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pg_en_q <= PG_EN_RST;
      end else if (ce && cmd_write && cmd_hit(CMD_PG_EN)) begin
         pg_en_q <= cmd_wdata[8:0];
      end
   end

   // read mux and unmapped-code detection
   always_comb begin
      rd_d  = 16'h0000;
      err_d = 1'b0;
      case (cmd_code)
         CMD_CFG_ALL: rd_d = {13'h0000, cfg_q};
         CMD_PROP_A:  rd_d = {15'h0000, prop_a_q[cmd_page]};
         CMD_PROP_B:  rd_d = {15'h0000, prop_b_q[cmd_page]};
         CMD_RESP_A:  rd_d = {12'h000, resp_a_q[{cmd_page[2], 2'b00} +: 4]};
         CMD_RESP_B:  rd_d = {12'h000, resp_b_q[{cmd_page[2], 2'b00} +: 4]};
         CMD_PG_EN:   rd_d = {7'h00, pg_en_q};
         CMD_STATUS:  rd_d = {8'h00, status_q};
         default:     err_d = 1'b1;
      endcase
   end

   // answer registers, one cycle after the command
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rd_data_q  <= 16'h0000;
         rd_valid_q <= 1'b0;
         cmd_err_q  <= 1'b0;
         rd_code_q  <= 8'h00;
      end else if (ce) begin
         rd_valid_q <= cmd_valid && !cmd_write && !err_d;
         cmd_err_q  <= cmd_valid && err_d;
         if (cmd_valid && !cmd_write) begin
            rd_data_q <= rd_d;
            rd_code_q <= cmd_code;
         end
      end
   end

   // packet check: reject a packet lacking a pec only when required
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pec_reject_q <= 1'b0;
      end else if (ce) begin
         pec_reject_q <= pkt_done && !pkt_has_pec && cfg_q[CFG_PEC_BIT];
      end
   end

   // bus timeout counter, interval stretched eightfold on request
   assign to_limit = cfg_q[CFG_LONG_BIT] ? TO_LONG : TO_BASE;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         to_cnt_q      <= 32'h0000_0000;
         bus_timeout_q <= 1'b0;
      end else if (ce) begin
         if (!bus_busy) begin
            to_cnt_q      <= 32'h0000_0000;
            bus_timeout_q <= 1'b0;
         end else begin
            if (to_cnt_q < to_limit) to_cnt_q <= to_cnt_q + 32'h0000_0001;
            bus_timeout_q <= (to_cnt_q == to_limit - 32'h0000_0001);
         end
      end
   end

   // input-enable output: pull low when forced off, else pull-up or float
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         vin_en_low_q    <= 1'b0;
         vin_en_pullup_q <= 1'b0;
      end else if (ce) begin
         vin_en_low_q    <= vin_en_force_off;
         vin_en_pullup_q <= !vin_en_force_off && !cfg_q[CFG_WPU_BIT];
      end
   end

   // zone pin drive requests from faulted-off channels
   always_comb begin
      drive_req_d[0] = |(chan_faulted_off[3:0] & prop_a_q[3:0]);
      drive_req_d[1] = |(chan_faulted_off[3:0] & prop_b_q[3:0]);
      drive_req_d[2] = |(chan_faulted_off[7:4] & prop_a_q[7:4]);
      drive_req_d[3] = |(chan_faulted_off[7:4] & prop_b_q[7:4]);
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) drive_req_q <= 4'h0;
      else if (ce) drive_req_q <= drive_req_d;
   end

   // link-side reset release, two flops from the core reset level
   always_ff @(posedge link_clk) begin
      lrst_q <= {lrst_q[0], rst_n};
   end
   assign lrst_n = lrst_q[1];

   // fault pin levels enter the link domain
   assign pin_raw_low = ~{zone1_fault_pin_b_i, zone1_fault_pin_a_i, zone0_fault_pin_b_i, zone0_fault_pin_a_i};
   fzpg_sync #(.W(NUM_PIN)) u_pin_sync (
      .clk   (link_clk),
      .rst_n (lrst_n),
      .d     (pin_raw_low),
      .q     (pin_low_link)
   );

   // drive requests cross into the link domain
   fzpg_sync #(.W(NUM_PIN)) u_drv_sync (
      .clk   (link_clk),
      .rst_n (lrst_n),
      .d     (drive_req_q),
      .q     (drive_link)
   );

   // open-drain drivers and registered pin state on the link clock
   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         fault_oe_q <= 4'h0;
         pin_low_q  <= 4'h0;
      end else begin
         fault_oe_q <= drive_link;
         pin_low_q  <= pin_low_link;
      end
   end
   assign zone0_fault_pin_a_oe_q = fault_oe_q[0];
   assign zone0_fault_pin_b_oe_q = fault_oe_q[1];
   assign zone1_fault_pin_a_oe_q = fault_oe_q[2];
   assign zone1_fault_pin_b_oe_q = fault_oe_q[3];
   assign zone0_fault_pin_a_o_q  = 1'b0;
   assign zone0_fault_pin_b_o_q  = 1'b0;
   assign zone1_fault_pin_a_o_q  = 1'b0;
   assign zone1_fault_pin_b_o_q  = 1'b0;
   assign alert_output_o_q       = 1'b0;

   // pin state back into the core domain
   fzpg_sync #(.W(NUM_PIN)) u_pin_core (
      .clk   (core_clk),
      .rst_n (rst_n),
      .d     (pin_low_q),
      .q     (pin_low_core)
   );

   // 10 us qualification per pin
   genvar gp;
   generate
      for (gp = 0; gp < NUM_PIN; gp++) begin : g_qual
         fzpg_qual #(.CYC(PIN_QUAL_CYC)) u_qual (
            .clk     (core_clk),
            .rst_n   (rst_n),
            .ce      (ce),
            .pin_low (pin_low_core[gp]),
            .qual_q  (pin_qual[gp])
         );
      end
   endgenerate

   // channel shutdown: only pins of its own zone with response set
   genvar gc;
   generate
      for (gc = 0; gc < NUM_CH; gc++) begin : g_chan
         localparam int Z = gc / 4;
         assign pin_off_d[gc] = (resp_a_q[gc] && pin_qual[2*Z]) || (resp_b_q[gc] && pin_qual[2*Z+1]);
      end
   endgenerate

   // sticky status, set on shutdown wins over a write-one clear
   always_comb begin
      status_d = status_q;
      if (cmd_write && cmd_hit(CMD_STATUS)) status_d = status_q & ~cmd_wdata[7:0];
      status_d = status_d | (pin_off_d & ~chan_pin_off_q);
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         chan_pin_off_q    <= 8'h00;
         status_q          <= 8'h00;
         alert_output_oe_q <= 1'b0;
      end else if (ce) begin
         chan_pin_off_q    <= pin_off_d;
         status_q          <= status_d;
         alert_output_oe_q <= |status_d;
      end
   end

   // power-good: AND of enabled sources, odd high-res channels excluded
   assign pg_eff = pg_en_q[7:0] & ~(adc_hires & ODD_CH_MASK);
   assign pg_d   = (&(chan_pg | ~pg_eff)) && (!pg_en_q[PG_WDOG_BIT] || wdog_ok);
   always_ff @(posedge core_clk) begin
      if (!rst_n) pwrgd_q <= 1'b0;
      else if (ce) pwrgd_q <= pg_d;
   end

   // checks on the core clock
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_pec_reject: assert property (ce && pkt_done && !pkt_has_pec && cfg_q[2] |=> pec_reject_q)
      else $error("missing pec not rejected");
   a_pec_accept: assert property (ce && pkt_done && pkt_has_pec |=> !pec_reject_q)
      else $error("packet with pec rejected");
   a_timeout_len: assert property ($rose(bus_timeout_q) |-> to_cnt_q == to_limit)
      else $error("timeout at wrong count");
   a_pullup_gate: assert property (ce && (vin_en_force_off || cfg_q[0]) |=> !vin_en_pullup_q)
      else $error("pull-up active when disabled or forced");
   a_zone1_only: assert property (ce && (chan_faulted_off[7:4] & prop_a_q[7:4]) == 4'h0 |=> !drive_req_q[2])
      else $error("zone1 pin driven without zone1 channel");
   a_pin_a_drive: assert property (ce && |(chan_faulted_off[3:0] & prop_a_q[3:0]) |=> drive_req_q[0])
      else $error("first pin not driven");
   a_pin_b_idle: assert property (ce && (chan_faulted_off[3:0] & prop_b_q[3:0]) == 4'h0 |=> !drive_req_q[1])
      else $error("second pin driven when not enabled");
   a_prop_rsvd: assert property (rd_valid_q && (rd_code_q == CMD_PROP_A || rd_code_q == CMD_PROP_B)
                                 |-> rd_data_q[15:1] == 15'h0000)
      else $error("propagate reserved bits nonzero");
   a_ignore_pin: assert property (ce && !resp_a_q[0] && !resp_b_q[0] |=> !chan_pin_off_q[0])
      else $error("channel shut with response zero");
   a_pg_chan: assert property (ce && pg_en_q[0] && !chan_pg[0] |=> !pwrgd_q)
      else $error("enabled bad channel kept power-good");
   a_pg_wdog: assert property (ce && pg_en_q[8] && !wdog_ok |=> !pwrgd_q)
      else $error("expired watchdog kept power-good");
   a_pg_hires: assert property (ce && pg_en_q == 9'h003 && adc_hires[1] && chan_pg[0] |=> pwrgd_q)
      else $error("high-res odd channel blocked power-good");
   a_pg_rsvd: assert property (rd_valid_q && rd_code_q == CMD_PG_EN |-> rd_data_q[15:9] == 7'h00)
      else $error("power-good reserved bits nonzero");
   a_pin_shut: assert property (ce && pin_qual[0] && resp_a_q[1] |=> chan_pin_off_q[1])
      else $error("channel not shut on qualified pin");
   a_alert_low: assert property (ce && status_q != 8'h00 && !(cmd_write && cmd_hit(CMD_STATUS))
                                 |=> alert_output_oe_q)
      else $error("alert not driven with status set");
   a_pg_all_good: assert property (ce && (&(chan_pg | ~pg_eff)) && (!pg_en_q[8] || wdog_ok) |=> pwrgd_q)
      else $error("power-good not asserted");

   c_pin_shutdown: cover property ($rose(chan_pin_off_q[0]));
   c_pg_rise:      cover property ($rose(pwrgd_q));
   c_timeout:      cover property ($rose(bus_timeout_q));
   c_pec_reject:   cover property (pec_reject_q);
endmodule

// *** tb/fzpg_peer.sv ***
// fzpg_peer: peer power managers and pull-ups on the four shared fault pins
// assumes the dut enables are link-clock registers; peers switch on the link clock
`timescale 1ns/1ps
module fzpg_peer (
   input  wire logic       link_clk,
   input  wire logic [3:0] pull_req,
   input  wire logic [3:0] dut_oe,
   output logic      [3:0] pin
);
   logic [3:0] peer_q = 4'h0;
   // peers take a new pull request on their own clock edge
   always_ff @(posedge link_clk) begin
      peer_q <= pull_req;
   end
   // wired-low with pull-up: any party pulling wins, a released pin reads high
   assign pin = ~(peer_q | dut_oe);
endmodule

// *** tb/tb_fault_zone_and_power_good_config.sv ***
// tb_fault_zone_and_power_good_config: directed bench for fzpg_top
// assumes the peer model on the fault pins and a short bus timeout parameter
`timescale 1ns/1ps
module tb_fault_zone_and_power_good_config;
   import fzpg_pkg::*;
   localparam int TO = 20;
   logic        core_clk, link_clk, rst_n, cmd_valid, cmd_write;
   logic [7:0]  cmd_code;
   logic [2:0]  cmd_page;
   logic [15:0] cmd_wdata, rd_data_q;
   logic        rd_valid_q, cmd_err_q, pkt_done, pkt_has_pec, pec_reject_q, bus_busy, bus_timeout_q;
   logic        vin_en_force_off, vin_en_pullup_q, vin_en_low_q, wdog_ok, pwrgd_q;
   logic [7:0]  chan_faulted_off, chan_pg, adc_hires, chan_pin_off_q;
   logic        alert_o, alert_oe, ce;
   logic [3:0]  pin, dut_oe, pin_o, pull_req;
   int          bad_count, n_checks, cyc;

   fzpg_top #(.TO_CYC(TO)) u_fzpg_top (
      .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .link_clk(link_clk),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_page(cmd_page),
      .cmd_wdata(cmd_wdata), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .cmd_err_q(cmd_err_q),
      .pkt_done(pkt_done), .pkt_has_pec(pkt_has_pec), .pec_reject_q(pec_reject_q),
      .bus_busy(bus_busy), .bus_timeout_q(bus_timeout_q), .vin_en_force_off(vin_en_force_off),
      .vin_en_pullup_q(vin_en_pullup_q), .vin_en_low_q(vin_en_low_q),
      .chan_faulted_off(chan_faulted_off), .chan_pg(chan_pg), .adc_hires(adc_hires),
      .wdog_ok(wdog_ok), .chan_pin_off_q(chan_pin_off_q), .alert_output_o_q(alert_o),
      .alert_output_oe_q(alert_oe), .pwrgd_q(pwrgd_q),
      .zone0_fault_pin_a_i(pin[0]), .zone0_fault_pin_a_o_q(pin_o[0]), .zone0_fault_pin_a_oe_q(dut_oe[0]),
      .zone0_fault_pin_b_i(pin[1]), .zone0_fault_pin_b_o_q(pin_o[1]), .zone0_fault_pin_b_oe_q(dut_oe[1]),
      .zone1_fault_pin_a_i(pin[2]), .zone1_fault_pin_a_o_q(pin_o[2]), .zone1_fault_pin_a_oe_q(dut_oe[2]),
      .zone1_fault_pin_b_i(pin[3]), .zone1_fault_pin_b_o_q(pin_o[3]), .zone1_fault_pin_b_oe_q(dut_oe[3])
   );

   fzpg_peer u_fzpg_peer (.link_clk(link_clk), .pull_req(pull_req), .dut_oe(dut_oe), .pin(pin));

   // core clock and an unrelated link clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      link_clk = 1'b0;
      #37;
      forever #80 link_clk = ~link_clk;
   end

   task automatic complete_run;
      if (bad_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         complete_run();
      end
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // one command, held for the taking edge; the answer is visible on return
   task automatic cmd(input logic wr, input logic [7:0] code, input logic [2:0] page, input logic [15:0] wd);
      @(posedge core_clk);
      #1;
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_code  = code;
      cmd_page  = page;
      cmd_wdata = wd;
      step(1);
      cmd_valid = 1'b0;
   endtask

   task automatic rd(input logic [7:0] code, input logic [2:0] page, input logic [15:0] exp, input string name);
      cmd(1'b0, code, page, 16'h0000);
      check("rd_valid", {15'h0000, rd_valid_q}, 16'h0001);
      check(name, rd_data_q, exp);
   endtask

   // reset values, reserved bits and an unmapped code
   task automatic t_regs;
      rd(CMD_CFG_ALL, 3'h0, 16'h0000, "cfg_rst");
      rd(CMD_PROP_A, 3'h0, 16'h0000, "prop_a_rst");
      rd(CMD_PROP_B, 3'h4, 16'h0000, "prop_b_rst");
      rd(CMD_PG_EN, 3'h0, 16'h0000, "pg_rst");
      cmd(1'b1, CMD_PROP_A, 3'h0, 16'hFFFF);
      rd(CMD_PROP_A, 3'h0, 16'h0001, "prop_a_rsv");
      cmd(1'b1, CMD_PROP_B, 3'h0, 16'hFFFE);
      rd(CMD_PROP_B, 3'h0, 16'h0000, "prop_b_rsv");
      cmd(1'b1, CMD_PG_EN, 3'h0, 16'hFFFF);
      rd(CMD_PG_EN, 3'h0, 16'h01FF, "pg_rsv");
      // a write while the clock enable is low must not land
      ce = 1'b0;
      cmd(1'b1, CMD_PG_EN, 3'h0, 16'h0000);
      ce = 1'b1;
      rd(CMD_PG_EN, 3'h0, 16'h01FF, "ce_hold");
      cmd(1'b1, CMD_PROP_A, 3'h0, 16'h0000);
      cmd(1'b0, 8'h00, 3'h0, 16'h0000);
      check("cmd_err", {15'h0000, cmd_err_q}, 16'h0001);
   endtask

   // faulted-off channels pulling their own zone's pins
   task automatic t_prop;
      logic [7:0] fo [4] = '{8'h02, 8'h42, 8'hBD, 8'h00};
      logic [3:0] ex [4] = '{4'h1, 4'h9, 4'h0, 4'h0};
      cmd(1'b1, CMD_PROP_A, 3'h1, 16'h0001);
      cmd(1'b1, CMD_PROP_B, 3'h6, 16'h0001);
      for (int i = 0; i < 4; i++) begin
         chan_faulted_off = fo[i];
         step(100);
         check("fault_oe", {12'h000, dut_oe}, {12'h000, ex[i]});
         check("fault_pin", {12'h000, pin}, {12'h000, ~ex[i]});
         check("fault_o", {12'h000, pin_o}, 16'h0000);
      end
      cmd(1'b1, CMD_PROP_A, 3'h1, 16'h0000);
      cmd(1'b1, CMD_PROP_B, 3'h6, 16'h0000);
   endtask

   // peer pulls a zone-0 pin with response off, then on
   task automatic t_resp;
      int n;
      pull_req = 4'h1;
      step(1300);
      check("ignore_off", {8'h00, chan_pin_off_q}, 16'h0000);
      check("ignore_alert", {15'h0000, alert_oe}, 16'h0000);
      pull_req = 4'h0;
      step(100);
      cmd(1'b1, CMD_RESP_A, 3'h0, 16'h0003);
      cmd(1'b1, CMD_RESP_B, 3'h4, 16'h0001);
      pull_req = 4'h1;
      step(990);
      check("early_off", {8'h00, chan_pin_off_q}, 16'h0000);
      n = 0;
      while (chan_pin_off_q === 8'h00 && n < 200) begin
         step(1);
         n++;
      end
      check("pin_off", {8'h00, chan_pin_off_q}, 16'h0003);
      check("alert", {15'h0000, alert_oe}, 16'h0001);
      check("alert_o", {15'h0000, alert_o}, 16'h0000);
      rd(CMD_STATUS, 3'h0, 16'h0003, "status");
      pull_req = 4'h0;
      n = 0;
      while (chan_pin_off_q !== 8'h00 && n < 200) begin
         step(1);
         n++;
      end
      check("restart", {8'h00, chan_pin_off_q}, 16'h0000);
      check("alert_held", {15'h0000, alert_oe}, 16'h0001);
      cmd(1'b1, CMD_STATUS, 3'h0, 16'h00FF);
      step(2);
      check("alert_clr", {15'h0000, alert_oe}, 16'h0000);
      cmd(1'b1, CMD_RESP_A, 3'h0, 16'h0000);
      cmd(1'b1, CMD_RESP_B, 3'h4, 16'h0000);
   endtask

   function automatic logic pg_exp(input logic [8:0] en, input logic [7:0] pg, input logic [7:0] hr, input logic wd);
      logic [7:0] use_m;
      use_m = en[7:0] & ~(hr & 8'hAA);
      return ((pg & use_m) == use_m) && (wd || !en[8]);
   endfunction

   // power-good mapping over enables, odd high-res channels and watchdog
   task automatic t_pg;
      logic [8:0] en [10] = '{9'h001, 9'h001, 9'h002, 9'h002, 9'h100, 9'h100, 9'h000, 9'h0FF, 9'h004, 9'h003};
      logic [7:0] pg [10] = '{8'hFE, 8'h01, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h7F, 8'h00, 8'h01};
      logic [7:0] hr [10] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02};
      logic       wd [10] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
      for (int i = 0; i < 10; i++) begin
         cmd(1'b1, CMD_PG_EN, 3'h0, {7'h00, en[i]});
         chan_pg   = pg[i];
         adc_hires = hr[i];
         wdog_ok   = wd[i];
         step(1);
         check("pwrgd", {15'h0000, pwrgd_q}, {15'h0000, pg_exp(en[i], pg[i], hr[i], wd[i])});
      end
   endtask

   task automatic pkt(input logic has, input logic exp);
      @(posedge core_clk);
      #1;
      pkt_done    = 1'b1;
      pkt_has_pec = has;
      step(1);
      pkt_done = 1'b0;
      check("pec_reject", {15'h0000, pec_reject_q}, {15'h0000, exp});
   endtask

   task automatic busy_len(output int n);
      bus_busy = 1'b1;
      n = 0;
      while (bus_timeout_q !== 1'b1 && n < 400) begin
         step(1);
         n++;
      end
      bus_busy = 1'b0;
      step(2);
   endtask

   // packet check, long timeout and input-enable pull-up
   task automatic t_cfg;
      int ns;
      int nl;
      step(2);
      check("pullup_on", {14'h0000, vin_en_pullup_q, vin_en_low_q}, 16'h0002);
      pkt(1'b0, 1'b0);
      busy_len(ns);
      cmd(1'b1, CMD_CFG_ALL, 3'h0, 16'h0006);
      pkt(1'b0, 1'b1);
      pkt(1'b1, 1'b0);
      busy_len(nl);
      check("long_to", 16'(nl - ns), 16'(7 * TO));
      cmd(1'b1, CMD_CFG_ALL, 3'h5, 16'h0001);
      rd(CMD_CFG_ALL, 3'h5, 16'h0001, "cfg_rd");
      step(2);
      check("pullup_off", {14'h0000, vin_en_pullup_q, vin_en_low_q}, 16'h0000);
      cmd(1'b1, CMD_CFG_ALL, 3'h0, 16'h0000);
      vin_en_force_off = 1'b1;
      step(2);
      check("forced", {14'h0000, vin_en_pullup_q, vin_en_low_q}, 16'h0001);
      vin_en_force_off = 1'b0;
   endtask

   initial begin
      bad_count        = 0;
      n_checks         = 0;
      cyc              = 0;
      rst_n            = 1'b0;
      ce               = 1'b1;
      cmd_valid        = 1'b0;
      cmd_write        = 1'b0;
      cmd_code         = 8'h00;
      cmd_page         = 3'h0;
      cmd_wdata        = 16'h0000;
      pkt_done         = 1'b0;
      pkt_has_pec      = 1'b0;
      bus_busy         = 1'b0;
      vin_en_force_off = 1'b0;
      chan_faulted_off = 8'h00;
      chan_pg          = 8'hFF;
      adc_hires        = 8'h00;
      wdog_ok          = 1'b1;
      pull_req         = 4'h0;
      // long enough for the link-domain reset flops too
      step(56);
      rst_n = 1'b1;
      t_regs();
      t_prop();
      t_resp();
      t_pg();
      t_cfg();
      complete_run();
   end
endmodule
